// ---- dv/aps_selector_bench.sv ----
/* Bench for aps_selector with a level model, the stage model and the checker.
   Assumes the package register map and a 50 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module aps_selector_bench;
	import aps_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cv = 0, vt = 0, trip = 0, dcm_o, wb_ack_o;
	logic [7:0] adr = '0;
	logic [31:0] wdat = '0, rdat, wb_dat_o;
	logic [15:0] cur = '0, freq = '0;
	logic [2:0] phase_count_o, running;
	logic [5:0] phase_enable_o;
	aps_pin_t pin = APS_PIN_HIZ;
	aps_pin_t pins[3] = '{APS_PIN_LOW, APS_PIN_HIGH, APS_PIN_HIZ};
	int pexp[3] = '{3, 6, 6};
	int pmode[3] = '{2, 1, 0};
	int error_cnt = 0, checks = 0, lvl = 6, hys, thr[7];
	always #10 clk_i = ~clk_i;
	aps_selector aps_selector_i(.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .load_current_i(cur), .current_valid_i(cv),
		.phase_select_pin_i(pin), .voltage_transition_i(vt), .feedback_window_trip_i(trip),
		.switching_freq_i(freq), .phase_count_o, .dcm_o, .phase_enable_o);
	aps_stage_model aps_stage_model_i(.pwm_en_i(phase_enable_o), .running_o(running));
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic expect_state(int c, bit d);
		chk("state", {c[2:0], d, c[2:0]}, {phase_count_o, dcm_o, running});
	endtask : expect_state
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Only the watchdog ends a wait for an ack that never comes
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rdat = wb_dat_o;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask : bus
	// ---
	// Report: the level model moves one step only when automatic and not forced
	// ---
	task automatic report(int i);
		cur <= 16'(i);
		cv <= 1;
		@(posedge clk_i);
		cv <= 0;
		if (pin == APS_PIN_HIZ && !vt && !trip && freq <= 16'h0100) begin
			if (lvl > 0 && i <= thr[lvl-1]) lvl--;
			else if (lvl < 6 && i > thr[lvl] + hys) lvl++;
		end
		repeat (2) @(posedge clk_i);
	endtask : report
	initial begin
		void'($urandom(96969));
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		bus(0, APS_CONFIG_ADDR, 0);
		chk("config", 6, rdat);
		bus(0, APS_FREQ_LIMIT_ADDR, 0);
		chk("freq_limit", 16'hFFFF, rdat);
		for (int k = 0; k < 7; k++) begin
			thr[k] = 900 * k + $urandom_range(0, 400);
			bus(1, 8'(24 - 4 * k), thr[k]);
		end
		hys = $urandom_range(0, 300);
		bus(1, APS_HYS_ADDR, hys);
		bus(1, APS_LOW_CNT_ADDR, 3);
		bus(1, APS_FREQ_LIMIT_ADDR, 16'h0100);
		bus(0, APS_TWO_PHASE_LOW_ADDR, 0);
		chk("two_low", thr[2], rdat);
		bus(0, 8'h30, 0);
		chk("unmapped", 0, rdat);
		$display("registers done");
		for (int n = 0; n < 70; n++) begin
			report(n < 8 ? 0 : $urandom_range(0, 6500));
			expect_state(lvl == 0 ? 1 : lvl, lvl == 0);
			if (n == 7) begin
				bus(0, APS_STATUS_ADDR, 0);
				chk("status_dcm", (1 << APS_ST_DCM_BIT) | 1, rdat);
				// End points: exactly threshold plus hysteresis, one above, then exactly the threshold
				for (int j = 0; j < 3; j++) begin
					report(j == 2 ? thr[0] : thr[0] + hys + j);
					expect_state(lvl == 0 ? 1 : lvl, lvl == 0);
				end
			end
		end
		$display("ladder done");
		for (int k = 0; k < 3; k++) begin
			vt <= (k == 0);
			trip <= (k == 1);
			freq <= (k == 2) ? 16'h0101 : 16'h0100;
			lvl = 6;
			report(0);
			expect_state(6, 0);
			bus(0, APS_STATUS_ADDR, 0);
			chk("status_force", (1 << APS_ST_FORCE_BIT) | 6, rdat);
			vt <= 0;
			trip <= 0;
			// A frequency equal to the limit is not above it, so automatic mode resumes
			freq <= 16'h0100;
			repeat (3) @(posedge clk_i);
			report(0);
			expect_state(lvl, 0);
		end
		$display("overrides done");
		foreach (pins[k]) begin
			pin <= pins[k];
			lvl = 6;
			report(9000);
			expect_state(pexp[k], 0);
			bus(0, APS_STATUS_ADDR, 0);
			chk("status_mode", (pmode[k] << APS_ST_MODE_LSB) | (pexp[k] << APS_ST_CNT_LSB), rdat);
		end
		$display("pin modes done");
		stop_test();
	end
	initial begin
		#200000;
		error_cnt++;
		stop_test();
	end
endmodule : aps_selector_bench
bind aps_selector aps_selector_sva aps_selector_sva_i(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.current_valid_i, .phase_select_pin_i, .voltage_transition_i, .feedback_window_trip_i,
	.phase_count_o, .dcm_o, .phase_enable_o);
`default_nettype wire

// ---- dv/aps_selector_sva.sv ----
/* Checker for aps_selector, bound from the bench to the top module ports.
   Assumes configured full count stays at the reset value of six. */
`timescale 1ns/10ps
`default_nettype none
module aps_selector_sva
	import aps_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic current_valid_i,
	input wire aps_pin_t phase_select_pin_i,
	input wire logic voltage_transition_i,
	input wire logic feedback_window_trip_i,
	input wire logic [APS_CNT_W-1:0] phase_count_o,
	input wire logic dcm_o,
	input wire logic [5:0] phase_enable_o
);
	// ---
	// Properties
	// ---
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack after request");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_dynamic_voltage_transition_full: assert property (voltage_transition_i && phase_select_pin_i != APS_PIN_LOW |=>
		phase_count_o == APS_MAX_PHASES && !dcm_o) else $error("transition not full");
	chk_trip_full: assert property (feedback_window_trip_i && phase_select_pin_i != APS_PIN_LOW |=>
		phase_count_o == APS_MAX_PHASES && !dcm_o) else $error("trip not full");
	chk_pin_high: assert property (phase_select_pin_i == APS_PIN_HIGH |=>
		phase_count_o == APS_MAX_PHASES && !dcm_o) else $error("high pin not full");
	chk_low_ccm: assert property (phase_select_pin_i == APS_PIN_LOW |=> !dcm_o)
		else $error("low pin in dcm");
	chk_shed_cause: assert property (phase_count_o < $past(phase_count_o) |->
		$past(current_valid_i, 2) || $past(phase_select_pin_i) == APS_PIN_LOW) else $error("shed without report");
	chk_one_step: assert property (phase_count_o < $past(phase_count_o) && $past(phase_select_pin_i) != APS_PIN_LOW
		|-> phase_count_o + 3'h1 == $past(phase_count_o)) else $error("shed more than one");
	chk_enable_map: assert property ($countones(phase_enable_o) == phase_count_o &&
		((phase_enable_o + 7'h01) & phase_enable_o) == 7'h00) else $error("enables differ from count");
	chk_dcm_one: assert property (dcm_o |-> phase_count_o == 3'h1)
		else $error("dcm with several phases");
	cover property (dcm_o);
	cover property (voltage_transition_i ##1 !voltage_transition_i);
	cover property (phase_select_pin_i == APS_PIN_LOW);
endmodule : aps_selector_sva
`default_nettype wire

// ---- dv/aps_stage_model.sv ----
/* Power stage model: one stage runs while its phase enable is high.
   Assumes the enables are settled within each controller clock cycle. */
`timescale 1ns/10ps
`default_nettype none
module aps_stage_model
	import aps_pkg::*;
(
	input wire logic [5:0] pwm_en_i,
	output logic [APS_CNT_W-1:0] running_o
);
	always_comb begin
		running_o = '0;
		for (int k = 0; k < 6; k++)
			running_o = running_o + APS_CNT_W'(pwm_en_i[k]);
	end
endmodule : aps_stage_model
`default_nettype wire

// ---- inc/aps_pkg.sv ----
/*
 * Package for the automatic phase count selector: register map, field
 * layouts, reset values and the mode and level encodings.
 * Assumes a 32-bit classic Wishbone register bus with word-aligned registers.
 */
package aps_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] APS_SIX_PHASE_LOW_ADDR = 8'h00;
	localparam logic [7:0] APS_FIVE_PHASE_LOW_ADDR = 8'h04;
	localparam logic [7:0] APS_FOUR_PHASE_LOW_ADDR = 8'h08;
	localparam logic [7:0] APS_THREE_PHASE_LOW_ADDR = 8'h0C;
	localparam logic [7:0] APS_TWO_PHASE_LOW_ADDR = 8'h10;
	localparam logic [7:0] APS_ONE_PHASE_LOW_ADDR = 8'h14;
	localparam logic [7:0] APS_DCM_LOW_ADDR = 8'h18;
	localparam logic [7:0] APS_HYS_ADDR = 8'h1C;
	localparam logic [7:0] APS_CONFIG_ADDR = 8'h20;
	localparam logic [7:0] APS_LOW_CNT_ADDR = 8'h24;
	localparam logic [7:0] APS_FREQ_LIMIT_ADDR = 8'h28;
	localparam logic [7:0] APS_STATUS_ADDR = 8'h2C;

	// ----------------------------------------
	// Widths and field layouts
	// ----------------------------------------
	localparam int APS_CUR_W = 16;
	localparam int APS_FREQ_W = 16;
	localparam int APS_CNT_W = 3;
	localparam int APS_NUM_THR = 7;
	localparam logic [APS_CNT_W-1:0] APS_MAX_PHASES = 3'h6;
	localparam int APS_ST_CNT_LSB = 0;
	localparam int APS_ST_DCM_BIT = 3;
	localparam int APS_ST_FORCE_BIT = 4;
	localparam int APS_ST_MODE_LSB = 5;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [APS_CUR_W-1:0] APS_THR_RST = 16'h0000;
	localparam logic [APS_CUR_W-1:0] APS_HYS_RST = 16'h0000;
	localparam logic [APS_CNT_W-1:0] APS_CONFIG_RST = 3'h6;
	localparam logic [APS_CNT_W-1:0] APS_LOW_CNT_RST = 3'h1;
	localparam logic [APS_FREQ_W-1:0] APS_FREQ_LIMIT_RST = 16'hFFFF;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		APS_PIN_LOW = 2'h0,
		APS_PIN_HIGH = 2'h1,
		APS_PIN_HIZ = 2'h2
	} aps_pin_t;

	typedef enum logic [1:0] {
		APS_MODE_AUTO = 2'h0,
		APS_MODE_FORCE_HIGH = 2'h1,
		APS_MODE_FORCE_LOW = 2'h2
	} aps_mode_t;

	typedef struct packed {
		logic [APS_CNT_W-1:0] phases;
		logic dcm;
	} aps_power_state_t;

endpackage : aps_pkg

// ---- logic/aps_selector.sv ----
/*
 * Automatic phase count selector: picks the active phase count and the
 * conduction mode of the remaining phase from the load-current report,
 * the phase-select pin and the transient override inputs.
 * Assumes synchronous inputs on clk_i, a one-cycle report strobe from the
 * current monitor, and a classic Wishbone master on the register port.
 */
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Auto mode maps current to level ladder
// - Voltage transition forces the configured full count continuous
// - Settled voltage returns to automatic selection
// - Feedback window trip forces full phases
// - Frequency above limit forces full phases
// - Hysteresis added before moving back up
// - Pin high full, HiZ auto, low count
// - Forced low runs programmed low count while no override forces full phases
// - Forced high runs configured full count
module aps_selector
	import aps_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Load current report
	input wire logic [APS_CUR_W-1:0] load_current_i,
	input wire logic current_valid_i,
	// Phase-select pin, already resolved to three levels
	input wire aps_pin_t phase_select_pin_i,
	// Transient overrides
	input wire logic voltage_transition_i,
	input wire logic feedback_window_trip_i,
	input wire logic [APS_FREQ_W-1:0] switching_freq_i,
	// Power state
	output logic [APS_CNT_W-1:0] phase_count_o,
	output logic dcm_o,
	output logic [5:0] phase_enable_o
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [APS_CUR_W-1:0] thr [APS_NUM_THR];
	logic [APS_CUR_W-1:0] shedding_hysteresis;
	logic [APS_CNT_W-1:0] regulator_config_setting;
	logic [APS_CNT_W-1:0] low_phase_count_setting;
	logic [APS_FREQ_W-1:0] freq_limit;
	aps_power_state_t auto_state;
	aps_power_state_t out_state;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire logic bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic bus_wr = bus_req && wb_we_i;
	// Lanes 2 and 3 hold no register bits, so their enables are ignored
	wire logic lo_lane = wb_sel_i[0];
	wire logic hi_lane = wb_sel_i[1];
	wire aps_mode_t mode;
	wire logic force_full;

	function automatic logic [15:0] merge16(input logic [15:0] old_v);
		merge16 = {hi_lane ? wb_dat_i[15:8] : old_v[15:8], lo_lane ? wb_dat_i[7:0] : old_v[7:0]};
	endfunction : merge16

	genvar gi;
	generate
		for (gi = 0; gi < APS_NUM_THR; gi++) begin : g_thr
			localparam logic [7:0] ADDR = 8'(APS_SIX_PHASE_LOW_ADDR + gi * 4);
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					thr[gi] <= APS_THR_RST;
				end else if (bus_wr && wb_adr_i == ADDR) begin
					thr[gi] <= merge16(thr[gi]);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shedding_hysteresis <= APS_HYS_RST;
			regulator_config_setting <= APS_CONFIG_RST;
			low_phase_count_setting <= APS_LOW_CNT_RST;
			freq_limit <= APS_FREQ_LIMIT_RST;
		end else if (bus_wr) begin
			case (wb_adr_i)
				APS_HYS_ADDR: shedding_hysteresis <= merge16(shedding_hysteresis);
				APS_CONFIG_ADDR: if (lo_lane) regulator_config_setting <= wb_dat_i[APS_CNT_W-1:0];
				APS_LOW_CNT_ADDR: if (lo_lane) low_phase_count_setting <= wb_dat_i[APS_CNT_W-1:0];
				APS_FREQ_LIMIT_ADDR: freq_limit <= merge16(freq_limit);
				default: ;
			endcase
		end
	end

	// Single-cycle answer; unmapped reads return zero and writes are dropped
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		case (wb_adr_i)
			APS_SIX_PHASE_LOW_ADDR: rd_data = {16'h0000, thr[0]};
			APS_FIVE_PHASE_LOW_ADDR: rd_data = {16'h0000, thr[1]};
			APS_FOUR_PHASE_LOW_ADDR: rd_data = {16'h0000, thr[2]};
			APS_THREE_PHASE_LOW_ADDR: rd_data = {16'h0000, thr[3]};
			APS_TWO_PHASE_LOW_ADDR: rd_data = {16'h0000, thr[4]};
			APS_ONE_PHASE_LOW_ADDR: rd_data = {16'h0000, thr[5]};
			APS_DCM_LOW_ADDR: rd_data = {16'h0000, thr[6]};
			APS_HYS_ADDR: rd_data = {16'h0000, shedding_hysteresis};
			APS_CONFIG_ADDR: rd_data = {29'h0, regulator_config_setting};
			APS_LOW_CNT_ADDR: rd_data = {29'h0, low_phase_count_setting};
			APS_FREQ_LIMIT_ADDR: rd_data = {16'h0000, freq_limit};
			APS_STATUS_ADDR: rd_data = {25'h0, mode, force_full, out_state.dcm, out_state.phases};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Mode and overrides
	// ----------------------------------------
	assign mode = (phase_select_pin_i == APS_PIN_HIGH) ? APS_MODE_FORCE_HIGH :
		(phase_select_pin_i == APS_PIN_LOW) ? APS_MODE_FORCE_LOW : APS_MODE_AUTO;
	// Overrides are level-driven, so release is immediate once settled
	assign force_full = voltage_transition_i
		|| feedback_window_trip_i
		|| (switching_freq_i > freq_limit);

	// ----------------------------------------
	// Automatic level ladder
	// ----------------------------------------
	// Level index: 6..1 phases continuous, 0 means one phase discontinuous.
	// thr[0] is the six-phase low, thr[6] the discontinuous threshold.
	logic [APS_CNT_W-1:0] cur_level;
	logic [APS_CNT_W-1:0] next_level;
	wire logic [APS_CNT_W-1:0] max_level = (regulator_config_setting > APS_MAX_PHASES) ? APS_MAX_PHASES :
		(regulator_config_setting == 3'h0) ? 3'h1 : regulator_config_setting;

	// Threshold below a level: level L stays while load > thr for L-1 (level 0 is DCM)
	function automatic logic [APS_CUR_W:0] shed_thr(input logic [APS_CNT_W-1:0] lvl);
		shed_thr = {1'b0, thr[3'(3'h6 - lvl)]};
	endfunction : shed_thr

	always_comb begin
		next_level = cur_level;
		// Shed downward while load is at or below this level's low threshold
		if (cur_level != 3'h0 && {1'b0, load_current_i} <= shed_thr(3'(cur_level - 3'h1))) begin
			next_level = 3'(cur_level - 3'h1);
		// Add upward only once load clears the next level's low plus hysteresis
		end else if (cur_level < max_level &&
			{1'b0, load_current_i} > 17'(shed_thr(cur_level) + {1'b0, shedding_hysteresis})) begin
			next_level = 3'(cur_level + 3'h1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_level <= APS_MAX_PHASES;
		end else if (force_full || mode != APS_MODE_AUTO) begin
			cur_level <= max_level;
		end else if (current_valid_i) begin
			cur_level <= (next_level > max_level) ? max_level : next_level;
		end
	end

	assign auto_state = '{phases: (cur_level == 3'h0) ? 3'h1 : cur_level,
		dcm: (cur_level == 3'h0)};

	// ----------------------------------------
	// Output selection
	// ----------------------------------------
	aps_power_state_t next_out;
	always_comb begin
		next_out = auto_state;
		if (force_full) begin
			next_out = '{phases: max_level, dcm: 1'b0};
		end else begin
			case (mode)
				APS_MODE_FORCE_HIGH: next_out = '{phases: max_level, dcm: 1'b0};
				APS_MODE_FORCE_LOW: next_out = '{phases: low_phase_count_setting, dcm: 1'b0};
				APS_MODE_AUTO: next_out = auto_state;
				default: next_out = auto_state;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_state <= '{phases: APS_CONFIG_RST, dcm: 1'b0};
		end else begin
			out_state <= next_out;
		end
	end

	assign phase_count_o = out_state.phases;
	assign dcm_o = out_state.dcm;
	assign phase_enable_o = 6'((7'h01 << out_state.phases) - 7'h01);

endmodule : aps_selector

`default_nettype wire
